// file: dtsl_defs.svh
/*
 debug trigger and status logic: register offsets, field positions,
 reset values and counts.
 assumes: included by the synchroniser, top and testbench files by bare name.
*/
`ifndef DTSL_DEFS_SVH
`define DTSL_DEFS_SVH

`define DTSL_OFF_CTRL        12'h000
`define DTSL_OFF_TRIG        12'h004
`define DTSL_OFF_STAT        12'h008
`define DTSL_OFF_TRCH        12'h00C
`define DTSL_OFF_TRCL        12'h010
`define DTSL_OFF_CMPA        12'h014
`define DTSL_OFF_CMPB        12'h018

`define DTSL_CTRL_EN_BIT     7
`define DTSL_CTRL_ARM_BIT    6
`define DTSL_CTRL_BRK_BIT    4
`define DTSL_TRIG_TYPE_BIT   7
`define DTSL_TRIG_BEGIN_BIT  6
`define DTSL_TRIG_MASK       8'hCF
`define DTSL_STAT_AF_BIT     7
`define DTSL_STAT_BF_BIT     6
`define DTSL_STAT_ARMED_STATUS_FLAG_BIT   5

`define DTSL_RST_BYTE        8'h00
`define DTSL_RST_ADDR        16'h0000
`define DTSL_DEPTH           4'h8
`define DTSL_SYNC_RST        2'h0

`endif

// file: dtsl_pkg.sv
/*
 types for the debug trigger and status logic.
 assumes: nothing beyond the defines header.
*/
package dtsl_pkg;
    typedef enum logic [3:0] {
        DTSL_M_A_ONLY, DTSL_M_A_OR_B, DTSL_M_A_THEN_B, DTSL_M_EV_B,
        DTSL_M_A_THEN_EV_B, DTSL_M_A_AND_B, DTSL_M_A_NOT_B,
        DTSL_M_INSIDE, DTSL_M_OUTSIDE, DTSL_M_NONE9, DTSL_M_NONE10,
        DTSL_M_NONE11, DTSL_M_NONE12, DTSL_M_NONE13, DTSL_M_NONE14,
        DTSL_M_NONE15
    } dtsl_mode_t;

    typedef enum logic [1:0] {
        DTSL_IDLE,
        DTSL_WAIT_A,
        DTSL_CAPTURE
    } dtsl_run_t;
endpackage : dtsl_pkg

// file: dtsl_sync.sv
/*
 three-stage synchroniser for a pin-level input; change seen once
 stages two and three agree.
 assumes: one clock, async active-low reset, clock enable.
*/
`timescale 1ns/1ps
`include "dtsl_defs.svh"
module dtsl_sync
    import dtsl_pkg::*;
(
    input  wire logic ref_clk_i,
    input  wire logic rstn_i,
    input  wire logic clk_en_i,
    input  wire logic async_i,
    output logic      level_o
);
    typedef struct packed {
        logic [2:0] stg;
        logic       lvl;
    } dtsl_sync_st_t;

    dtsl_sync_st_t s_q, s_d;

    always_comb begin
        s_d     = s_q;
        // first stage only feeds the second
        s_d.stg = {s_q.stg[1:0], async_i};
        if (s_q.stg[2] == s_q.stg[1]) begin
            s_d.lvl = s_q.stg[1];
        end
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s_q <= '0;
        end else if (clk_en_i) begin
            s_q <= s_d;
        end
    end

    assign level_o = s_q.lvl;
endmodule : dtsl_sync

// file: dtsl_top.sv
/*
 debug trigger and status logic: APB register slave, trigger mode
 decode, match flags, arm state, valid word count and break request.
 assumes: cpu bus strobes are on ref_clk_i; the secure strap comes
 from a pin; the trace store itself lives outside.
*/
// Added by the designer: the APB register port and the placing of the registers.
// Behaviour
// - trigger config always readable, written only while not armed
// - config bits 4 and 5 read zero, writes ignored
// - type bit 7 set: trigger only when matched opcode executes
// - begin bit 6: 0 circular until trigger, 1 trigger starts storage; code also starts it once match flag A or B is set
// - event-only modes ignore begin bit, always begin trace
// - modes 0 to 4: A, A or B, A then B, event B, A then event B
// - modes 5 to 8: A and B, A not B, inside range, outside range
// - mode codes 9 to 15 never trigger
// - match A flag clears at run start, sets on A match
// - match B flag clears at run start, sets on B match
// - armed flag mirrors arm bit while enabled; writing 1 sets it
// - run ends on full in begin trace, on trigger in end trace
// - writing 0 to arm or enable stops the run, clears armed
// - valid count clears at run start, counts words up to eight
// - count not decremented by reads; host counts its own reads
// - status register read-only, writes change nothing
// - low byte read advances buffer, high byte read does not
// - enable bit cannot be set while device is secured
// - break on trigger in end trace, on full in begin trace
`timescale 1ns/1ps
`include "dtsl_defs.svh"
module dtsl_top
    import dtsl_pkg::*;
#(
    parameter int AW = 16
) (
    input  wire logic          ref_clk_i,
    input  wire logic          rstn_i,
    input  wire logic          clk_en_i,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [11:0]   paddr,
    input  wire logic [31:0]   pwdata,
    output logic      [31:0]   prdata,
    output logic               pready,
    output logic               pslverr,
    input  wire logic          secure_i,
    input  wire logic          bus_valid_i,
    input  wire logic [AW-1:0] bus_addr_i,
    input  wire logic          opcode_exec_i,
    input  wire logic [AW-1:0] exec_addr_i,
    input  wire logic          store_i,
    input  wire logic [15:0]   trace_word_i,
    output logic               trace_advance_o,
    output logic               trace_store_o,
    output logic               break_req_o,
    output logic               armed_o
);
    //////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic [7:0]    ctrl;
        logic [7:0]    trig;
        logic          af;
        logic          bf;
        logic          armed_status_flag;
        logic [3:0]    cnt;
        logic [AW-1:0] cmpa;
        logic [AW-1:0] cmpb;
        dtsl_run_t     run;
        logic [31:0]   rdata;
        logic          ready;
        logic          err;
        logic          adv;
        logic          stor;
        logic          brk;
    } dtsl_st_t;

    dtsl_st_t s_q, s_d;
    logic     secure_s;

    dtsl_sync u_sec (
        .ref_clk_i (ref_clk_i),
        .rstn_i    (rstn_i),
        .clk_en_i  (clk_en_i),
        .async_i   (secure_i),
        .level_o   (secure_s)
    );

    // event-only modes force a begin trace whatever the begin bit
    function automatic logic is_event_mode(input logic [3:0] m);
        return m == DTSL_M_EV_B || m == DTSL_M_A_THEN_EV_B;
    endfunction : is_event_mode

    function automatic logic hit(input logic [AW-1:0] a,
                                 input logic [AW-1:0] c);
        return a == c;
    endfunction : hit

    //////////////////////////////////////////////////////////////////////
    logic          acc, wr, rd, seen_a, seen_b, qual, trig_ev;
    logic          begin_tr, full, stop, wr_ctrl;
    logic [AW-1:0] qa;
    logic [7:0]    nctrl;

    always_comb begin
        s_d     = s_q;
        acc     = psel && penable && s_q.ready;
        wr      = acc && pwrite;
        // read data and error load with ready so they stand beside it
        rd      = psel && penable && !s_q.ready;
        wr_ctrl = wr && paddr == `DTSL_OFF_CTRL;
        s_d.adv  = 1'b0;
        s_d.stor = 1'b0;
        s_d.brk  = 1'b0;
        // one wait state: ready rises at the end of the first access cycle
        s_d.ready = psel && penable && !s_q.ready;
        s_d.err   = 1'b0;
        // tagged trigger qualifies on executed opcode address
        qual = s_q.trig[`DTSL_TRIG_TYPE_BIT] ? opcode_exec_i : bus_valid_i;
        qa   = s_q.trig[`DTSL_TRIG_TYPE_BIT] ? exec_addr_i : bus_addr_i;
        seen_a = qual && hit(qa, s_q.cmpa);
        seen_b = qual && hit(qa, s_q.cmpb);
        trig_ev = 1'b0;
        unique case (dtsl_mode_t'(s_q.trig[3:0]))
            DTSL_M_A_ONLY:      trig_ev = seen_a;
            DTSL_M_A_OR_B:      trig_ev = seen_a || seen_b;
            DTSL_M_A_THEN_B,
            DTSL_M_A_THEN_EV_B: trig_ev = s_q.run == DTSL_WAIT_A ? 1'b0
                                          : seen_b;
            DTSL_M_EV_B:        trig_ev = seen_b;
            DTSL_M_A_AND_B:     trig_ev = seen_a && seen_b;
            DTSL_M_A_NOT_B:     trig_ev = seen_a && !seen_b;
            DTSL_M_INSIDE:      trig_ev = qual && qa >= s_q.cmpa
                                          && qa <= s_q.cmpb;
            DTSL_M_OUTSIDE:     trig_ev = qual && (qa < s_q.cmpa
                                          || qa > s_q.cmpb);
            default:            trig_ev = 1'b0;
        endcase
        begin_tr = s_q.trig[`DTSL_TRIG_BEGIN_BIT]
                   || is_event_mode(s_q.trig[3:0]);
        full = s_q.cnt == `DTSL_DEPTH;
        stop = 1'b0;

        // sticky while armed, cleared at run start below
        if (s_q.armed_status_flag && seen_a) begin
            s_d.af = 1'b1;
        end
        if (s_q.armed_status_flag && seen_b) begin
            s_d.bf = 1'b1;
        end

        unique case (s_q.run)
            DTSL_IDLE: begin
            end
            DTSL_WAIT_A: begin
                if (seen_a) begin
                    s_d.run = DTSL_CAPTURE;
                end
            end
            DTSL_CAPTURE: begin
                if (begin_tr) begin
                    if (s_q.af || s_q.bf || trig_ev || s_q.stor) begin
                        s_d.stor = store_i && !full;
                    end
                    if (s_q.stor && !full) begin
                        s_d.cnt = s_q.cnt + 4'h1;
                    end
                    if (full) begin
                        stop    = 1'b1;
                        s_d.brk = s_q.ctrl[`DTSL_CTRL_BRK_BIT];
                    end
                end else begin
                    // circular fill, count saturates at depth
                    s_d.stor = store_i;
                    if (s_q.stor && !full) begin
                        s_d.cnt = s_q.cnt + 4'h1;
                    end
                    if (trig_ev) begin
                        stop    = 1'b1;
                        s_d.brk = s_q.ctrl[`DTSL_CTRL_BRK_BIT];
                    end
                end
            end
        endcase
        if (stop) begin
            s_d.run = DTSL_IDLE;
            s_d.stor = 1'b0;
            s_d.ctrl[`DTSL_CTRL_ARM_BIT] = 1'b0;
            s_d.armed_status_flag = 1'b0;
        end

        //////////////////////////////////////////////////////////////////
        if (wr_ctrl) begin
            nctrl = pwdata[7:0];
            if (secure_s && !s_q.ctrl[`DTSL_CTRL_EN_BIT]) begin
                nctrl[`DTSL_CTRL_EN_BIT] = 1'b0;
            end
            if (!nctrl[`DTSL_CTRL_EN_BIT]) begin
                nctrl[`DTSL_CTRL_ARM_BIT] = 1'b0;
            end
            s_d.ctrl = nctrl;
            if (!nctrl[`DTSL_CTRL_ARM_BIT]) begin
                s_d.armed_status_flag = 1'b0;
                s_d.run  = DTSL_IDLE;
                s_d.stor = 1'b0;
            end else if (!s_q.armed_status_flag) begin
                s_d.armed_status_flag = 1'b1;
                s_d.af   = 1'b0;
                s_d.bf   = 1'b0;
                s_d.cnt  = 4'h0;
                s_d.run  = (s_q.trig[3:0] == 4'h2
                            || s_q.trig[3:0] == 4'h4)
                           ? DTSL_WAIT_A : DTSL_CAPTURE;
            end
        end else begin
            nctrl = s_q.ctrl;
        end
        if (wr && paddr == `DTSL_OFF_TRIG && !s_q.ctrl[`DTSL_CTRL_ARM_BIT]) begin
            s_d.trig = pwdata[7:0] & `DTSL_TRIG_MASK;
        end
        if (wr && paddr == `DTSL_OFF_CMPA && !s_q.armed_status_flag) begin
            s_d.cmpa = pwdata[AW-1:0];
        end
        if (wr && paddr == `DTSL_OFF_CMPB && !s_q.armed_status_flag) begin
            s_d.cmpb = pwdata[AW-1:0];
        end

        // status offset has no write path
        if (rd && !pwrite) begin
            s_d.rdata = 32'h0000_0000;
            unique case (paddr)
                `DTSL_OFF_CTRL: s_d.rdata[7:0] = s_q.ctrl;
                `DTSL_OFF_TRIG: s_d.rdata[7:0] = s_q.trig;
                `DTSL_OFF_STAT: s_d.rdata[7:0] = {s_q.af, s_q.bf, s_q.armed_status_flag,
                                                  1'b0, s_q.cnt};
                `DTSL_OFF_TRCH: s_d.rdata[7:0] = trace_word_i[15:8];
                `DTSL_OFF_TRCL: begin
                    s_d.rdata[7:0] = trace_word_i[7:0];
                    s_d.adv = 1'b1;
                end
                `DTSL_OFF_CMPA: s_d.rdata[AW-1:0] = s_q.cmpa;
                `DTSL_OFF_CMPB: s_d.rdata[AW-1:0] = s_q.cmpb;
                default:        s_d.err = 1'b1;
            endcase
        end else if (rd) begin
            unique case (paddr)
                `DTSL_OFF_CTRL, `DTSL_OFF_TRIG, `DTSL_OFF_STAT,
                `DTSL_OFF_TRCH, `DTSL_OFF_TRCL, `DTSL_OFF_CMPA,
                `DTSL_OFF_CMPB: s_d.err = 1'b0;
                default:        s_d.err = 1'b1;
            endcase
        end
        // new enable value, so enable and arm written together still arm
        if (!s_d.ctrl[`DTSL_CTRL_EN_BIT]) begin
            s_d.armed_status_flag = 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s_q <= '0;
        end else if (clk_en_i) begin
            s_q <= s_d;
        end
    end

    //////////////////////////////////////////////////////////////////////
    assign prdata          = s_q.rdata;
    assign pready          = s_q.ready;
    assign pslverr         = s_q.err;
    assign trace_advance_o = s_q.adv;
    assign trace_store_o   = s_q.stor;
    assign break_req_o     = s_q.brk;
    assign armed_o         = s_q.armed_status_flag;

    //////////////////////////////////////////////////////////////////////
    sequence arm_write_s;
        wr_ctrl && pwdata[`DTSL_CTRL_ARM_BIT] && pwdata[`DTSL_CTRL_EN_BIT]
        && s_q.ctrl[`DTSL_CTRL_EN_BIT] && !s_q.armed_status_flag && clk_en_i;
    endsequence

    sequence full_stop_s;
        s_q.run == DTSL_CAPTURE && begin_tr && full && !wr_ctrl
        && clk_en_i;
    endsequence

    a_trig_write_lock: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        s_q.ctrl[`DTSL_CTRL_ARM_BIT] |=> $stable(s_q.trig) || $past(!clk_en_i))
        else $error("trigger config changed while armed");
    a_trig_zero_bits: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        s_q.trig[5:4] == 2'h0)
        else $error("config bits 4 and 5 not zero");
    a_arm_sets_flag: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        arm_write_s |=> armed_o && s_q.cnt == 4'h0 && !s_q.af && !s_q.bf)
        else $error("arming did not set flag and clear status");
    a_no_trig_modes: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        s_q.trig[3:0] > 4'h8 |-> !trig_ev)
        else $error("reserved mode produced a trigger");
    a_disarm_clears: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        wr_ctrl && !pwdata[`DTSL_CTRL_ARM_BIT] && clk_en_i |=> !armed_o)
        else $error("manual stop left armed flag set");
    a_count_bound: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        s_q.cnt <= `DTSL_DEPTH)
        else $error("valid count above depth");
    a_secure_enable: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        secure_s && !s_q.ctrl[`DTSL_CTRL_EN_BIT] && clk_en_i
        |=> !s_q.ctrl[`DTSL_CTRL_EN_BIT])
        else $error("enable set while secured");
    a_end_on_trig: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        s_q.run == DTSL_CAPTURE && !begin_tr && trig_ev && !wr_ctrl
        && clk_en_i |=> !armed_o ##0 break_req_o
                        == $past(s_q.ctrl[`DTSL_CTRL_BRK_BIT]))
        else $error("end trace did not stop on trigger");
    a_low_advance: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        trace_advance_o |-> $past(paddr) == `DTSL_OFF_TRCL)
        else $error("advance without low byte read");
    // pulses stand one cycle; a frozen clock enable holds them longer
    a_ready_one_cycle: assert property (@(posedge ref_clk_i)
        disable iff (!rstn_i) pready && clk_en_i |=> !pready)
        else $error("pready stood more than one cycle");
    a_err_with_ready: assert property (@(posedge ref_clk_i)
        disable iff (!rstn_i) pslverr |-> pready)
        else $error("pslverr without pready");
    a_flag_a_sets: assert property (@(posedge ref_clk_i)
        disable iff (!rstn_i)
        s_q.armed_status_flag && seen_a && !wr_ctrl && clk_en_i |=> s_q.af)
        else $error("match A flag not set");
    a_flag_b_sets: assert property (@(posedge ref_clk_i)
        disable iff (!rstn_i)
        s_q.armed_status_flag && seen_b && !wr_ctrl && clk_en_i |=> s_q.bf)
        else $error("match B flag not set");
    a_tag_qualify: assert property (@(posedge ref_clk_i)
        disable iff (!rstn_i) s_q.trig[`DTSL_TRIG_TYPE_BIT]
        && !opcode_exec_i |-> !seen_a && !seen_b)
        else $error("match without executed opcode");
    a_end_on_full: assert property (@(posedge ref_clk_i)
        disable iff (!rstn_i) full_stop_s |=> !armed_o ##0 break_req_o
                        == $past(s_q.ctrl[`DTSL_CTRL_BRK_BIT]))
        else $error("begin trace did not stop when full");
    a_advance_once: assert property (@(posedge ref_clk_i)
        disable iff (!rstn_i) trace_advance_o && clk_en_i
        |=> !trace_advance_o)
        else $error("advance stood more than one cycle");
    a_break_enable: assert property (@(posedge ref_clk_i)
        disable iff (!rstn_i) !s_q.ctrl[`DTSL_CTRL_BRK_BIT] && clk_en_i
        |=> !break_req_o)
        else $error("break without break enable");
    a_begin_waits: assert property (@(posedge ref_clk_i)
        disable iff (!rstn_i) s_q.run == DTSL_CAPTURE && begin_tr
        && !s_q.af && !s_q.bf && !s_q.stor && !trig_ev && clk_en_i
        |=> !trace_store_o)
        else $error("begin trace stored before trigger");
endmodule : dtsl_top

// file: dtsl_far_model.sv
/*
 far side model: cpu bus cycles, opcode execution and trace store
 strobes, plus a trace head word that never stands still.
 assumes: drive is called from the bench process between clock edges.
*/
`timescale 1ns/1ps
module dtsl_far_model (
    input  wire logic        ref_clk_i,
    output logic             bus_valid_o,
    output logic [15:0]      bus_addr_o,
    output logic             exec_o,
    output logic [15:0]      exec_addr_o,
    output logic             store_o,
    output logic [15:0]      word_o
);
    initial begin
        bus_valid_o = 1'b0;
        bus_addr_o  = 16'h0000;
        exec_o      = 1'b0;
        exec_addr_o = 16'h0000;
        store_o     = 1'b0;
        word_o      = 16'h0000;
    end

    // moving head word so a stale sample never looks right
    always @(posedge ref_clk_i) word_o <= word_o + 16'h1357;

    ////////////////////////////////////////////////////////////////////
    // k 0: bus access, 1: opcode executed, 2: store strobe
    task automatic drive(input int k, input logic [15:0] a);
        @(posedge ref_clk_i);
        bus_valid_o <= (k == 0);
        exec_o      <= (k == 1);
        store_o     <= (k == 2);
        bus_addr_o  <= a;
        exec_addr_o <= a;
        @(posedge ref_clk_i);
        bus_valid_o <= 1'b0;
        exec_o      <= 1'b0;
        store_o     <= 1'b0;
        // released bus shows the inverse, not the last address
        bus_addr_o  <= ~a;
        exec_addr_o <= ~a;
    endtask : drive
endmodule : dtsl_far_model

// file: dtsl_top_tb.sv
/*
 testbench for the debug trigger and status logic: apb tasks, run
 scenarios per capture style and a sweep over all mode codes.
 assumes: read data and pslverr stand with pready; far side from
 dtsl_far_model.
*/
`timescale 1ns/1ps
`include "dtsl_defs.svh"
module dtsl_top_tb;
    import dtsl_pkg::*;
    localparam logic [15:0] A = 16'h1000;
    localparam logic [15:0] B = 16'h2000;
    localparam logic [15:0] C = 16'h3000;
    logic        ref_clk_i, rstn_i, psel, penable, pwrite, secure_i;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, v;
    logic        pready, pslverr, last_err, bv, ex, st;
    logic [15:0] ba, ea, tw, tw_s;
    logic        adv, sto, brk, armed_o;
    int          n_errors, n_compared, n_adv, n_brk;
    logic [15:0] a1 [9] = '{B, B, B, B, B, A, B, 16'h0FFF, B};
    logic [15:0] a2 [9] = '{B, B, A, B, B, B, A, B, 16'h0FFF};
    logic [8:0]  ends = 9'h1C2;

    dtsl_top dut_u (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
        .clk_en_i(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .secure_i(secure_i), .bus_valid_i(bv),
        .bus_addr_i(ba), .opcode_exec_i(ex), .exec_addr_i(ea),
        .store_i(st), .trace_word_i(tw), .trace_advance_o(adv),
        .trace_store_o(sto), .break_req_o(brk), .armed_o(armed_o));
    dtsl_far_model far_u (.ref_clk_i(ref_clk_i), .bus_valid_o(bv),
        .bus_addr_o(ba), .exec_o(ex), .exec_addr_o(ea), .store_o(st),
        .word_o(tw));

    initial begin
        ref_clk_i = 1'b0;
        forever #10 ref_clk_i = ~ref_clk_i;
    end
    always @(posedge ref_clk_i) begin
        if (adv === 1'b1) n_adv++;
        if (brk === 1'b1) n_brk++;
    end

    ////////////////////////////////////////////////////////////////////
    task automatic close_out;
        $display("errors %0d compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : close_out

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // request held until pready is sampled high, then released
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        int k;
        @(posedge ref_clk_i);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge ref_clk_i);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge ref_clk_i);
            k++;
            // head word at the last edge before pready, where data loads
            if (pready !== 1'b1) tw_s = tw;
        end while (pready !== 1'b1 && k < 20);
        if (k >= 20) begin
            n_errors++;
            close_out();
        end
        v        = prdata;
        last_err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rchk(input string nm, input logic [11:0] a,
                        input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        check(nm, v, e);
    endtask : rchk

    task automatic arm(input logic [7:0] trig, input logic [7:0] ctrl);
        wr(`DTSL_OFF_TRIG, {24'h0, trig});
        wr(`DTSL_OFF_CTRL, {24'h0, ctrl});
        rchk("status at arm", `DTSL_OFF_STAT, 32'h20);
    endtask : arm

    // break and end of run land within one cycle; eight is a margin
    task automatic armed_is(input logic e);
        repeat (8) @(posedge ref_clk_i);
        check("armed", {31'h0, armed_o}, {31'h0, e});
    endtask : armed_is

    ////////////////////////////////////////////////////////////////////
    initial begin
        {rstn_i, psel, penable, pwrite, secure_i} = 5'h00;
        paddr  = 12'h000;
        pwdata = 32'h0000_0000;
        repeat (4) @(posedge ref_clk_i);
        rstn_i <= 1'b1;
        rchk("ctrl", `DTSL_OFF_CTRL, 32'h00);
        rchk("status", `DTSL_OFF_STAT, 32'h00);
        wr(`DTSL_OFF_TRIG, 32'hFF);
        rchk("trig", `DTSL_OFF_TRIG, 32'hCF);
        apb(1'b0, 12'h01C, 32'h0);
        check("unmapped err", {31'h0, last_err}, 32'h1);
        wr(`DTSL_OFF_CMPA, {16'h0, A});
        wr(`DTSL_OFF_CMPB, {16'h0, B});
        rchk("cmp a", `DTSL_OFF_CMPA, {16'h0, A});
        rchk("cmp b", `DTSL_OFF_CMPB, {16'h0, B});
        // end trace, a only, breaks enabled
        arm(8'h00, 8'hD0);
        wr(`DTSL_OFF_TRIG, 32'h07);
        rchk("trig armed", `DTSL_OFF_TRIG, 32'h00);
        repeat (3) far_u.drive(2, C);
        far_u.drive(0, B);
        armed_is(1'b1);
        far_u.drive(0, A);
        armed_is(1'b0);
        rchk("status end", `DTSL_OFF_STAT, 32'hC3);
        check("breaks", n_brk, 1);
        apb(1'b0, `DTSL_OFF_TRCH, 32'h0);
        check("trace high", v, {24'h0, tw_s[15:8]});
        repeat (2) @(posedge ref_clk_i);
        check("advance high", n_adv, 0);
        apb(1'b0, `DTSL_OFF_TRCL, 32'h0);
        check("trace low", v, {24'h0, tw_s[7:0]});
        repeat (2) @(posedge ref_clk_i);
        check("advance low", n_adv, 1);
        rchk("count kept", `DTSL_OFF_STAT, 32'hC3);
        wr(`DTSL_OFF_STAT, 32'hFF);
        rchk("status ro", `DTSL_OFF_STAT, 32'hC3);
        // begin trace: trigger opens storage, full ends the run
        arm(8'h40, 8'hD0);
        repeat (2) far_u.drive(2, C);
        far_u.drive(0, A);
        armed_is(1'b1);
        repeat (10) far_u.drive(2, C);
        armed_is(1'b0);
        rchk("status full", `DTSL_OFF_STAT, 32'h88);
        check("breaks", n_brk, 2);
        // opcode qualified: access alone must not trigger
        arm(8'h80, 8'hC0);
        far_u.drive(0, A);
        armed_is(1'b1);
        far_u.drive(1, A);
        armed_is(1'b0);
        // every mode code, end style asked for, manual stop after
        for (int m = 0; m < 16; m++) begin
            arm({4'h0, 4'(m)}, 8'hC0);
            far_u.drive(0, m < 9 ? a1[m] : A);
            far_u.drive(0, m < 9 ? a2[m] : B);
            armed_is(m < 9 ? ~ends[m] : 1'b1);
            wr(`DTSL_OFF_CTRL, 32'h80);
            armed_is(1'b0);
        end
        check("breaks off", n_brk, 2);
        secure_i <= 1'b1;
        wr(`DTSL_OFF_CTRL, 32'h00);
        repeat (6) @(posedge ref_clk_i);
        wr(`DTSL_OFF_CTRL, 32'h80);
        rchk("ctrl secure", `DTSL_OFF_CTRL, 32'h00);
        secure_i <= 1'b0;
        repeat (6) @(posedge ref_clk_i);
        wr(`DTSL_OFF_CTRL, 32'h80);
        rchk("ctrl open", `DTSL_OFF_CTRL, 32'h80);
        close_out();
    end
endmodule : dtsl_top_tb
